// ---- rtl/dusc_pkg.sv ----
// Constants shared by the unlock and seek command logic
package dusc_pkg;
  // Task-file register select
  localparam logic [2:0] REG_DATA      = 3'h0;
  localparam logic [2:0] REG_ERROR     = 3'h1;
  localparam logic [2:0] REG_SEC_COUNT = 3'h2;
  localparam logic [2:0] REG_SEC_NUM   = 3'h3;
  localparam logic [2:0] REG_CYL_LOW   = 3'h4;
  localparam logic [2:0] REG_CYL_HIGH  = 3'h5;
  localparam logic [2:0] REG_DEV_HEAD  = 3'h6;
  localparam logic [2:0] REG_STATUS    = 3'h7;

  // Command codes
  localparam logic [7:0] CMD_UNLOCK    = 8'hF2;
  localparam logic [3:0] CMD_SEEK_NIB  = 4'h7;

  // Error register bits
  localparam int unsigned ERR_ABORT_BIT    = 2;
  localparam int unsigned ERR_NOTFOUND_BIT = 4;

  // Status register bits
  localparam int unsigned ST_BUSY_BIT  = 7;
  localparam int unsigned ST_READY_BIT = 6;
  localparam int unsigned ST_SEEKC_BIT = 4;
  localparam int unsigned ST_DRQ_BIT   = 3;
  localparam int unsigned ST_ERR_BIT   = 0;

  // Device/head fields
  localparam int unsigned DH_LBA_BIT  = 6;
  localparam int unsigned DH_HEAD_MSB = 3;

  // Parameter sector layout
  localparam int unsigned PW_BITS          = 256;
  localparam logic [7:0]  WORD_CTRL        = 8'h00;
  localparam logic [7:0]  WORD_PW_FIRST    = 8'h01;
  localparam logic [7:0]  WORD_PW_LAST     = 8'h10;
  localparam logic [7:0]  WORD_SECTOR_LAST = 8'hFF;
  localparam int unsigned CTRL_ID_BIT      = 0;

  // Unlock attempt budget
  localparam logic [2:0] ATTEMPTS_INIT = 3'h5;
  localparam logic [2:0] ATTEMPTS_NONE = 3'h0;

  // Address field positions in block mode
  localparam int unsigned LBA_SEC_LSB  = 0;
  localparam int unsigned LBA_CYLL_LSB = 8;
  localparam int unsigned LBA_CYLH_LSB = 16;
  localparam int unsigned LBA_HEAD_LSB = 24;
  localparam int unsigned LBA_BITS     = 28;

  typedef enum logic [1:0] {
    DUSC_IDLE  = 2'b00,
    DUSC_XFER  = 2'b01,
    DUSC_CHECK = 2'b11,
    DUSC_SEEK  = 2'b10
  } dusc_state_t;
endpackage

// ---- rtl/dusc_unlock_seek.sv ----
// Command block logic for the unlock and seek commands
// How it works
// [R1] Good password leaves lock, password untouched
// [R2] Reset restores lock unless protection disabled
// [R3] One sector: id bit, 32-byte password
// [R4] Identifier bit chooses master or user
// [R5] Master at high level compares master
// [R6] Master at maximum level is rejected
// [R7] User identifier compares stored user password
// [R8] Mismatch aborts and decrements attempt counter
// [R9] Attempt counter starts at five
// [R10] Counter zero rejects protected commands until reset
// [R11] Protection disabled with user id aborts
// [R12] Abort after transfer means mismatch, master at maximum level, or protection disabled with user id
// [R13] Any 7x byte seeks track and head
// [R14] Seek works on unformatted medium
// [R15] Block mode target from four fields
// [R16] Cylinder/head mode uses cylinder and head
// [R17] Block mode returns current address in place
// [R18] Frozen state rejects unlock
// [R19] Abort sets abort flag, error, clears busy
`timescale 1ns/1ps
`default_nettype none
module dusc_unlock_seek #(
  parameter int unsigned PW_W = dusc_pkg::PW_BITS
) (
  input  wire logic                          clock_i,          // 20 MHz clock
  input  wire logic                          reset_i,          // Async reset, high
  input  wire logic [2:0]                    reg_addr_i,       // Task-file register select
  input  wire logic                          reg_wr_i,         // Register write strobe
  input  wire logic                          reg_rd_i,         // Register read strobe
  input  wire logic [7:0]                    reg_wdata_i,      // Register write data
  output logic      [7:0]                    reg_rdata_o,      // Read data, cycle after strobe
  input  wire logic                          data_wr_i,        // Sector word write strobe
  input  wire logic [15:0]                   data_i,           // Sector word
  input  wire logic [PW_W-1:0]               user_pw_i,        // Stored user password
  input  wire logic [PW_W-1:0]               master_pw_i,      // Stored master password
  input  wire logic                          sec_enabled_i,    // Password protection on
  input  wire logic                          sec_max_i,        // Maximum security level
  input  wire logic                          frozen_i,         // Frozen mode
  input  wire logic                          seek_done_i,      // Mechanics finished seek
  input  wire logic                          seek_fail_i,      // Target not found, with done
  input  wire logic [dusc_pkg::LBA_BITS-1:0] cur_addr_i,       // Current block address
  output logic                               seek_start_o,     // Seek request pulse
  output logic                               seek_lba_o,       // Target is a block address
  output logic      [dusc_pkg::LBA_BITS-1:0] seek_target_o,    // Block address or cyl/head
  output logic                               locked_o,         // Device lock mode
  output logic      [2:0]                    attempts_o,       // Unlock attempts left
  output logic      [7:0]                    status_o,         // Status register image
  output logic      [7:0]                    error_o           // Error register image
);

  dusc_pkg::dusc_state_t state;
  dusc_pkg::dusc_state_t next_state;

  logic [7:0] sec_count;
  logic [7:0] sec_num;
  logic [7:0] cyl_low;
  logic [7:0] cyl_high;
  logic [7:0] dev_head;
  logic [7:0] word_idx;
  logic       id_master;
  logic       mismatch;
  logic       boot;

  logic       cmd_wr;
  logic       is_unlock;
  logic       is_seek;
  logic       unlock_reject;
  logic       xfer_last;
  logic       word_bad;
  logic       pw_fail;
  logic [15:0] stored_word;

  function automatic logic [15:0] pw_word(input logic [PW_W-1:0] pw, input logic [7:0] idx);
    logic [7:0] w;
    w = idx - dusc_pkg::WORD_PW_FIRST;
    pw_word = pw[{w[3:0], 4'h0} +: 16];
  endfunction

  assign cmd_wr    = reg_wr_i && (reg_addr_i == dusc_pkg::REG_STATUS)
                     && (state == dusc_pkg::DUSC_IDLE);
  assign is_unlock = (reg_wdata_i == dusc_pkg::CMD_UNLOCK);
  // [R13] Low nibble ignored
  assign is_seek   = (reg_wdata_i[7:4] == dusc_pkg::CMD_SEEK_NIB);

  // [R10] [R18] Rejected before any data moves
  assign unlock_reject = frozen_i || (attempts_o == dusc_pkg::ATTEMPTS_NONE);

  assign xfer_last = data_wr_i && (word_idx == dusc_pkg::WORD_SECTOR_LAST);

  // [R4] Identifier picks the stored password
  assign stored_word = id_master ? pw_word(master_pw_i, word_idx)
                                 : pw_word(user_pw_i, word_idx);
  assign word_bad = (word_idx >= dusc_pkg::WORD_PW_FIRST)
                    && (word_idx <= dusc_pkg::WORD_PW_LAST)
                    && (data_i != stored_word);

  // [R5] [R6] [R7] [R11] Checked once the identifier is known
  assign pw_fail = mismatch
                   || (id_master && sec_max_i)
                   || (!id_master && !sec_enabled_i);

  always_comb begin
    next_state = state;
    case (state)
      dusc_pkg::DUSC_IDLE: begin
        if (cmd_wr && is_unlock && !unlock_reject) begin
          next_state = dusc_pkg::DUSC_XFER;
        end else if (cmd_wr && is_seek) begin
          next_state = dusc_pkg::DUSC_SEEK;
        end
      end
      dusc_pkg::DUSC_XFER: begin
        // [R3] Exactly one sector accepted
        if (xfer_last) begin
          next_state = dusc_pkg::DUSC_CHECK;
        end
      end
      dusc_pkg::DUSC_CHECK: begin
        next_state = dusc_pkg::DUSC_IDLE;
      end
      dusc_pkg::DUSC_SEEK: begin
        if (seek_done_i) begin
          next_state = dusc_pkg::DUSC_IDLE;
        end
      end
      default: begin
        next_state = dusc_pkg::DUSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= dusc_pkg::DUSC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Sector word counter and running compare
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      word_idx  <= dusc_pkg::WORD_CTRL;
      id_master <= 1'b0;
      mismatch  <= 1'b0;
    end else if (state != dusc_pkg::DUSC_XFER) begin
      word_idx <= dusc_pkg::WORD_CTRL;
      if (state == dusc_pkg::DUSC_IDLE) begin
        mismatch <= 1'b0;
      end
    end else if (data_wr_i) begin
      word_idx <= word_idx + 8'h01;
      // [R3] Word 0 bit 0 is the identifier
      if (word_idx == dusc_pkg::WORD_CTRL) begin
        id_master <= data_i[dusc_pkg::CTRL_ID_BIT];
      end
      if (word_bad) begin
        mismatch <= 1'b1;
      end
    end
  end

  // Attempt counter; only reset refills it
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      // [R9] Loaded with five
      attempts_o <= dusc_pkg::ATTEMPTS_INIT;
    end else if (state == dusc_pkg::DUSC_CHECK && mismatch
                 && attempts_o != dusc_pkg::ATTEMPTS_NONE) begin
      // [R8] One step per mismatch
      attempts_o <= attempts_o - 3'h1;
    end
  end

  // Lock state; reset cannot sample the input, so it settles on the first edge
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      boot     <= 1'b1;
      locked_o <= 1'b1;
    end else begin
      boot <= 1'b0;
      if (!sec_enabled_i) begin
        // [R2] Disabled protection leaves no lock
        locked_o <= 1'b0;
      end else if (state == dusc_pkg::DUSC_CHECK && !pw_fail) begin
        // [R1] Unlock only; stored passwords are inputs
        locked_o <= 1'b0;
      end else if (boot) begin
        // [R2] Lock restored after reset
        locked_o <= 1'b1;
      end
    end
  end

  // Task-file registers written by the host
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sec_count <= 8'h00;
      sec_num   <= 8'h00;
      cyl_low   <= 8'h00;
      cyl_high  <= 8'h00;
      dev_head  <= 8'h00;
    end else if (state == dusc_pkg::DUSC_SEEK && seek_done_i && dev_head[dusc_pkg::DH_LBA_BIT]) begin
      // [R17] Current address in the input positions
      sec_num  <= cur_addr_i[dusc_pkg::LBA_SEC_LSB +: 8];
      cyl_low  <= cur_addr_i[dusc_pkg::LBA_CYLL_LSB +: 8];
      cyl_high <= cur_addr_i[dusc_pkg::LBA_CYLH_LSB +: 8];
      dev_head <= {dev_head[7:4], cur_addr_i[dusc_pkg::LBA_HEAD_LSB +: 4]};
    end else if (reg_wr_i && state == dusc_pkg::DUSC_IDLE) begin
      case (reg_addr_i)
        dusc_pkg::REG_SEC_COUNT: begin
          sec_count <= reg_wdata_i;
        end
        dusc_pkg::REG_SEC_NUM: begin
          sec_num <= reg_wdata_i;
        end
        dusc_pkg::REG_CYL_LOW: begin
          cyl_low <= reg_wdata_i;
        end
        dusc_pkg::REG_CYL_HIGH: begin
          cyl_high <= reg_wdata_i;
        end
        dusc_pkg::REG_DEV_HEAD: begin
          dev_head <= reg_wdata_i;
        end
        default: begin
          sec_count <= sec_count;
        end
      endcase
    end
  end

  // Seek request to the mechanics; no format check, so blank media seek too
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      seek_start_o  <= 1'b0;
      seek_lba_o    <= 1'b0;
      seek_target_o <= '0;
    end else begin
      // [R13] [R14] Start on any seek code
      seek_start_o <= cmd_wr && is_seek && !(is_unlock);
      if (cmd_wr && is_seek) begin
        seek_lba_o <= dev_head[dusc_pkg::DH_LBA_BIT];
        if (dev_head[dusc_pkg::DH_LBA_BIT]) begin
          // [R15] Four fields form the block address
          seek_target_o <= {dev_head[dusc_pkg::DH_HEAD_MSB:0], cyl_high, cyl_low, sec_num};
        end else begin
          // [R16] Head over cylinder, sector bits zero
          seek_target_o <= {dev_head[dusc_pkg::DH_HEAD_MSB:0], cyl_high, cyl_low, 8'h00};
        end
      end
    end
  end

  // Error register; a new command clears the previous outcome
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      error_o <= 8'h00;
    end else if (cmd_wr) begin
      error_o <= 8'h00;
      if (is_unlock && unlock_reject) begin
        // [R10] [R18] [R19] Immediate abort
        error_o[dusc_pkg::ERR_ABORT_BIT] <= 1'b1;
      end else if (!is_unlock && !is_seek) begin
        // [R19] Codes this block does not own
        error_o[dusc_pkg::ERR_ABORT_BIT] <= 1'b1;
      end
    end else if (state == dusc_pkg::DUSC_CHECK && pw_fail) begin
      // [R8] [R12] [R19] Abort after the sector
      error_o[dusc_pkg::ERR_ABORT_BIT] <= 1'b1;
    end else if (state == dusc_pkg::DUSC_SEEK && seek_done_i && seek_fail_i) begin
      error_o[dusc_pkg::ERR_NOTFOUND_BIT] <= 1'b1;
    end
  end

  // Status register image
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      status_o <= 8'h00;
    end else begin
      status_o <= 8'h00;
      status_o[dusc_pkg::ST_READY_BIT] <= 1'b1;
      case (next_state)
        dusc_pkg::DUSC_XFER: begin
          status_o[dusc_pkg::ST_DRQ_BIT] <= 1'b1;
        end
        dusc_pkg::DUSC_CHECK, dusc_pkg::DUSC_SEEK: begin
          status_o[dusc_pkg::ST_BUSY_BIT] <= 1'b1;
        end
        default: begin
          // [R19] Idle means busy clear; error mirrors the error register
          status_o[dusc_pkg::ST_SEEKC_BIT] <= 1'b1;
          if (cmd_wr) begin
            status_o[dusc_pkg::ST_ERR_BIT] <= (is_unlock && unlock_reject)
                                              || (!is_unlock && !is_seek);
          end else if (state == dusc_pkg::DUSC_CHECK) begin
            status_o[dusc_pkg::ST_ERR_BIT] <= pw_fail;
          end else if (state == dusc_pkg::DUSC_SEEK) begin
            status_o[dusc_pkg::ST_ERR_BIT] <= seek_fail_i;
          end else begin
            status_o[dusc_pkg::ST_ERR_BIT] <= status_o[dusc_pkg::ST_ERR_BIT];
          end
        end
      endcase
    end
  end

  // Registered read port
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        dusc_pkg::REG_ERROR: begin
          reg_rdata_o <= error_o;
        end
        dusc_pkg::REG_SEC_COUNT: begin
          reg_rdata_o <= sec_count;
        end
        dusc_pkg::REG_SEC_NUM: begin
          reg_rdata_o <= sec_num;
        end
        dusc_pkg::REG_CYL_LOW: begin
          reg_rdata_o <= cyl_low;
        end
        dusc_pkg::REG_CYL_HIGH: begin
          reg_rdata_o <= cyl_high;
        end
        dusc_pkg::REG_DEV_HEAD: begin
          reg_rdata_o <= dev_head;
        end
        dusc_pkg::REG_STATUS: begin
          reg_rdata_o <= status_o;
        end
        default: begin
          reg_rdata_o <= 8'h00;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- testbench/dusc_mech_model.sv ----
// Behavioural head mechanics answering seek requests
`timescale 1ns/1ps
`default_nettype none
module dusc_mech_model (
  input  wire logic        clock_i,  // Clock
  input  wire logic        reset_i,  // Async reset, high
  input  wire logic        start_i,  // Seek request pulse
  input  wire logic [27:0] target_i, // Requested address
  input  wire logic        fail_i,   // Make this seek miss
  input  wire logic [3:0]  delay_i,  // Settle time in cycles
  output logic             done_o,   // Seek finished pulse
  output logic             fail_o,   // Miss, valid with done
  output logic      [27:0] addr_o    // Landed block address
);
  logic [4:0] cnt;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= 5'h0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
      addr_o <= 28'h0;
    end else begin
      done_o <= 1'b0;
      // Toggles outside done so a stale level is never trusted
      fail_o <= ~fail_o;
      if (start_i) begin
        cnt <= {1'b0, delay_i} + 5'h1;
      end else if (cnt != 5'h0) begin
        cnt <= cnt - 5'h1;
        if (cnt == 5'h1) begin
          done_o <= 1'b1;
          fail_o <= fail_i;
          // Lands one block past, so echoed registers show up
          addr_o <= target_i + 28'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/dusc_properties.sv ----
// Concurrent checks on the unlock and seek command logic
`timescale 1ns/1ps
`default_nettype none
module dusc_properties (
  input wire logic       clock_i,       // Clock
  input wire logic       reset_i,       // Async reset
  input wire logic [2:0] reg_addr_i,    // Register select
  input wire logic       reg_wr_i,      // Write strobe
  input wire logic       reg_rd_i,      // Read strobe
  input wire logic [7:0] reg_wdata_i,   // Write data
  input wire logic [7:0] reg_rdata_o,   // Read data
  input wire logic       sec_enabled_i, // Protection on
  input wire logic       frozen_i,      // Frozen mode
  input wire logic       seek_start_o,  // Seek pulse
  input wire logic       locked_o,      // Lock mode
  input wire logic [2:0] attempts_o,    // Attempts left
  input wire logic [7:0] status_o,      // Status image
  input wire logic [7:0] error_o        // Error image
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic cmd_wr;
  assign cmd_wr = reg_wr_i && reg_addr_i == 3'h7 && !status_o[7] && !status_o[3];

  a_seek_launch: assert property (cmd_wr && reg_wdata_i[7:4] == 4'h7
    |=> seek_start_o && status_o[7]) else $error("seek command did not launch");
  a_seek_pulse: assert property (seek_start_o |=> !seek_start_o)
    else $error("seek start longer than one cycle");
  a_unlock_drq: assert property (cmd_wr && reg_wdata_i == 8'hF2 && !frozen_i
    && attempts_o != 3'h0 |=> status_o == 8'h48) else $error("unlock gave no data request");
  a_frozen_abort: assert property (cmd_wr && reg_wdata_i == 8'hF2 && frozen_i
    |=> error_o == 8'h04 && status_o == 8'h51) else $error("frozen unlock not refused");
  a_spent_abort: assert property (cmd_wr && reg_wdata_i == 8'hF2 && attempts_o == 3'h0
    |=> error_o == 8'h04 && status_o == 8'h51) else $error("spent counter not refused");
  a_attempt_step: assert property (attempts_o != $past(attempts_o)
    |-> attempts_o == $past(attempts_o) - 3'h1 && error_o[2]) else $error("bad attempt step");
  a_abort_flags: assert property (error_o[2] |-> status_o[0] && !status_o[7]
    && !status_o[3]) else $error("abort without error status");
  a_read_status: assert property (reg_rd_i && reg_addr_i == 3'h7
    |=> reg_rdata_o == $past(status_o)) else $error("status read wrong");
  a_unlock_mode: assert property ($fell(locked_o) && sec_enabled_i
    |-> error_o == 8'h00 && status_o == 8'h50) else $error("unlocked without success");
  c_unlock_pass: cover property ($fell(locked_o));
  c_abort: cover property ($rose(error_o[2]));
  c_seek: cover property (seek_start_o);
endmodule
bind dusc_unlock_seek dusc_properties u_props (.clock_i(clock_i), .reset_i(reset_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .sec_enabled_i(sec_enabled_i),
  .frozen_i(frozen_i), .seek_start_o(seek_start_o), .locked_o(locked_o),
  .attempts_o(attempts_o), .status_o(status_o), .error_o(error_o));
`default_nettype wire

// ---- testbench/drive_unlock_and_seek_cmds_tb.sv ----
// Self-checking bench for the unlock and seek command logic
`timescale 1ns/1ps
`default_nettype none
module drive_unlock_and_seek_cmds_tb;
  localparam int D = 5;
  logic         clock_i, reset_i, reg_wr_i, reg_rd_i, data_wr_i, sec_en, sec_max, frozen;
  logic         fail_req, done, fail, start, lba, locked;
  logic [2:0]   reg_addr, attempts;
  logic [3:0]   dly;
  logic [7:0]   wdata, rdata, status, error;
  logic [15:0]  data;
  logic [255:0] user_pw, master_pw;
  logic [27:0]  cur, target, t, t_next;
  int           n_mismatch, compares, seed, i, j, k;
  logic [7:0]   q_exp[$];
  string        q_name[$];

  dusc_unlock_seek DUT (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .data_wr_i(data_wr_i), .data_i(data), .user_pw_i(user_pw), .master_pw_i(master_pw),
    .sec_enabled_i(sec_en), .sec_max_i(sec_max), .frozen_i(frozen), .seek_done_i(done),
    .seek_fail_i(fail), .cur_addr_i(cur), .seek_start_o(start), .seek_lba_o(lba),
    .seek_target_o(target), .locked_o(locked), .attempts_o(attempts), .status_o(status),
    .error_o(error));
  dusc_mech_model u_mech (.clock_i(clock_i), .reset_i(reset_i), .start_i(start),
    .target_i(target), .fail_i(fail_req), .delay_i(dly), .done_o(done), .fail_o(fail),
    .addr_o(cur));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tick;
    @(posedge clock_i);
    #D;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr = a;
    wdata = d;
    reg_wr_i = 1'b1;
    tick;
    reg_wr_i = 1'b0;
    tick;
  endtask
  task automatic rd(input logic [2:0] a, input string n, input logic [7:0] e);
    q_exp.push_back(e);
    q_name.push_back(n);
    reg_addr = a;
    reg_rd_i = 1'b1;
    tick;
    reg_rd_i = 1'b0;
    tick;
  endtask
  // Read data is checked a cycle after the strobe edge
  always @(posedge clock_i) begin
    if (reg_rd_i === 1'b1) begin
      @(posedge clock_i);
      #1;
      chk(q_name.pop_front(), rdata, q_exp.pop_front());
    end
  end
  task automatic wait_idle;
    for (i = 0; i < 200 && status[7] !== 1'b0; i++) tick;
    chk("busy", status[7], 1'b0);
  endtask
  task automatic do_reset;
    reset_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #D;
    reset_i = 1'b0;
    tick;
  endtask
  task automatic unlock(input logic x, input logic id, input logic [255:0] pw,
                        input logic [7:0] st);
    wr(3'h7, 8'hF2);
    for (k = 0; x && k < 256; k++) begin
      data = (k == 0) ? {15'h0, id} : (k <= 16) ? pw[(k-1)*16 +: 16] : 16'($random(seed));
      data_wr_i = 1'b1;
      tick;
      data_wr_i = 1'b0;
      tick;
    end
    wait_idle;
    rd(3'h7, "status", st);
    rd(3'h1, "error", {5'h0, st[0], 2'h0});
  endtask
  task automatic seek(input logic l, input logic f, input logic [3:0] nib);
    t = 28'($random(seed));
    fail_req = f;
    dly = 4'($random(seed));
    wr(3'h3, t[7:0]);
    wr(3'h4, t[15:8]);
    wr(3'h5, t[23:16]);
    wr(3'h6, {1'b0, l, 2'h0, t[27:24]});
    wr(3'h7, {4'h7, nib});
    wait_idle;
    // Mechanics land one block past the target
    t_next = t + 28'h1;
    chk("target", target, l ? t : {t[27:8], 8'h00});
    chk("lba", lba, l);
    rd(3'h7, "status", f ? 8'h51 : 8'h50);
    rd(3'h1, "error", f ? 8'h10 : 8'h00);
    if (l && !f) begin
      rd(3'h3, "secnum", t_next[7:0]);
      rd(3'h4, "cyllow", t_next[15:8]);
      rd(3'h5, "cylhigh", t_next[23:16]);
      rd(3'h6, "head", {4'h4, t_next[27:24]});
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #1_000_000;
    n_mismatch++;
    summarize;
  end

  initial begin
    {reset_i, seed, n_mismatch, compares} = {1'b1, 32'd68803, 64'd0};
    {reg_wr_i, reg_rd_i, data_wr_i, sec_max, frozen, fail_req} = 6'h0;
    {reg_addr, wdata, data, dly, sec_en} = {3'h0, 8'h0, 16'h0, 4'h0, 1'b1};
    for (j = 0; j < 8; j++) {user_pw[j*32 +: 32], master_pw[j*32 +: 32]} = {$random(seed), $random(seed)};
    do_reset;
    chk("locked", locked, 1'b1);
    chk("attempts", attempts, 3'h5);
    unlock(1'b1, 1'b0, user_pw ^ 256'h1, 8'h51);
    sec_max = 1'b1;
    unlock(1'b1, 1'b1, master_pw, 8'h51);
    chk("attempts", attempts, 3'h4);
    sec_max = 1'b0;
    unlock(1'b1, 1'b1, master_pw, 8'h50);
    chk("locked", locked, 1'b0);
    $display("test master and user paths ended");
    do_reset;
    chk("locked", locked, 1'b1);
    for (j = 0; j < 5; j++) unlock(1'b1, 1'b0, master_pw, 8'h51);
    chk("attempts", attempts, 3'h0);
    unlock(1'b0, 1'b0, user_pw, 8'h51);
    chk("locked", locked, 1'b1);
    $display("test attempt budget ended");
    do_reset;
    frozen = 1'b1;
    unlock(1'b0, 1'b0, user_pw, 8'h51);
    frozen = 1'b0;
    unlock(1'b1, 1'b0, user_pw, 8'h50);
    sec_en = 1'b0;
    unlock(1'b1, 1'b0, user_pw, 8'h51);
    do_reset;
    chk("locked", locked, 1'b0);
    sec_en = 1'b1;
    $display("test frozen and disabled ended");
    for (j = 0; j < 16; j++) seek(j[0], j == 6, j[3:0]);
    $display("test seeks ended");
    t = 28'($random(seed));
    wr(3'h2, t[7:0]);
    rd(3'h2, "seccount", t[7:0]);
    // Codes outside unlock and seek abort at once
    wr(3'h7, 8'hA5);
    rd(3'h7, "status", 8'h51);
    rd(3'h1, "error", 8'h04);
    $display("test foreign code ended");
    summarize;
  end
endmodule
`default_nettype wire
